/* File: design/tts_ctrl.sv */
// Transmit timing select control: register, source selection, frame alignment and loss protection.
`timescale 1ns/10ps
module tts_ctrl
	import tts_pkg::*;
#(
	parameter int T1_BITS = TTS_T1_FRAME_BITS,
	parameter int E1_BITS = TTS_E1_FRAME_BITS,
	parameter int LOSS_LIMIT = TTS_LOSS_CYC
)
(
	input wire logic mclk,
	input wire logic rst,
	input wire tts_bus_req_t bus_req,
	output logic [7:0] rdata_ff,
	input wire logic rec_clk_tick,
	input wire logic recovery_ok,
	input wire logic tx_bit_tick,
	input wire logic ref_8k_tick,
	output tts_src_t tx_src_ff,
	output logic line_standard_ff,
	output logic violation_inject_ff,
	output logic frame_start_ff,
	output logic clock_loss_status_ff
);

	// ==========================================================
	// Parameter check: the frame counter is nine bits wide, and a frame needs at least two slots.
	if (T1_BITS < 2 || T1_BITS > 511 || E1_BITS < 2 || E1_BITS > 511)
	begin : g_bad_frame
		$error("tts_ctrl: frame length out of range");
	end

	// ==========================================================
	// Source code decode, used only by source selection; alignment gating tests the registered tx_src_ff.
	function automatic tts_src_t src_decode(input logic [1:0] code);
		tts_src_t s;
		s = TTS_SRC_LINE;
		if (code == 2'b01)
			s = TTS_SRC_EXT;
		else if (code == 2'b10)
			s = TTS_SRC_PLL;
		return s;
	endfunction : src_decode

	logic [7:0] csc_ff;
	logic [8:0] frame_cnt_ff;
	logic [8:0] frame_last;
	logic lost;
	logic viol_pending;
	logic wr_csc;
	logic rd_bis;
	logic arm_viol;
	logic prot_en;
	logic align_active;
	logic sub_active;
	tts_src_t sel_src;
	tts_src_t nxt_src;

	// ==========================================================
	// Register write and read decode.
	assign wr_csc = bus_req.wr && (bus_req.addr == TTS_CSC_ADDR);
	assign rd_bis = bus_req.rd && (bus_req.addr == TTS_BIS_ADDR);
	assign arm_viol = wr_csc && bus_req.wdata[TTS_VIOL_BIT] && !csc_ff[TTS_VIOL_BIT];

	// Control register; reserved bits 3:2 are kept at zero so reads never surprise software.
	always_ff @(posedge mclk)
	begin
		if (rst)
			csc_ff <= TTS_CSC_RESET;
		else if (wr_csc)
			csc_ff <= bus_req.wdata & TTS_CSC_WMASK;
	end

	assign prot_en = csc_ff[TTS_PROT_BIT];
	assign sel_src = src_decode(csc_ff[1:0]);
	assign sub_active = prot_en && (sel_src == TTS_SRC_LINE) && lost;
	assign align_active = csc_ff[TTS_ALIGN_BIT] && (tx_src_ff == TTS_SRC_PLL);

	// ==========================================================
	// Loss monitor and violation generator.
	tts_loss_mon #(.LIMIT(LOSS_LIMIT)) u_loss
	(
		.mclk(mclk),
		.rst(rst),
		.rec_tick(rec_clk_tick),
		.recovery_ok(recovery_ok),
		.lost_ff(lost)
	);

	tts_viol_gen u_viol
	(
		.mclk(mclk),
		.rst(rst),
		.arm(arm_viol),
		.bit_tick(tx_bit_tick),
		.pending_ff(viol_pending),
		.viol_ff(violation_inject_ff)
	);

	// ==========================================================
	// Effective transmit source: the PLL stands in only while line recovery is lost.
	always_comb
	begin
		nxt_src = sel_src;
		if (sub_active)
			nxt_src = TTS_SRC_PLL;
	end

	// The effective source is registered so that the output never glitches on a register write.
	always_ff @(posedge mclk)
	begin
		if (rst)
			tx_src_ff <= TTS_SRC_LINE;
		else
			tx_src_ff <= nxt_src;
	end

	// Line standard follows bit 6 directly.
	always_ff @(posedge mclk)
	begin
		if (rst)
			line_standard_ff <= 1'b0;
		else
			line_standard_ff <= csc_ff[TTS_STD_BIT];
	end

	// ==========================================================
	// Transmit frame counter. A reference tick restarts the frame when alignment is live;
	// this may shorten one frame, which is the price of a hard resync.
	assign frame_last = line_standard_ff ? 9'(T1_BITS - 1) : 9'(E1_BITS - 1);

	always_ff @(posedge mclk)
	begin
		if (rst)
			frame_cnt_ff <= 9'h000;
		else if (align_active && ref_8k_tick)
			frame_cnt_ff <= 9'h000;
		else if (tx_bit_tick)
		begin
			if (frame_cnt_ff >= frame_last)
				frame_cnt_ff <= 9'h000;
			else
				frame_cnt_ff <= frame_cnt_ff + 9'h001;
		end
	end

	// Frame start pulse for one cycle, from a wrap or from a reference restart.
	always_ff @(posedge mclk)
	begin
		if (rst)
			frame_start_ff <= 1'b0;
		else
			frame_start_ff <= (align_active && ref_8k_tick) || (tx_bit_tick && frame_cnt_ff >= frame_last);
	end

	// ==========================================================
	// Clock-loss status: sticky, cleared by reading it; a new loss in the read cycle wins.
	always_ff @(posedge mclk)
	begin
		if (rst)
			clock_loss_status_ff <= 1'b0;
		else if (prot_en && lost)
			clock_loss_status_ff <= 1'b1;
		else if (rd_bis)
			clock_loss_status_ff <= 1'b0;
	end

	// ==========================================================
	// Read data stand only in the cycle after the strobe; unmapped reads return zero.
	always_ff @(posedge mclk)
	begin
		if (rst)
			rdata_ff <= 8'h00;
		else if (!bus_req.rd)
			rdata_ff <= 8'h00;
		else if (bus_req.addr == TTS_CSC_ADDR)
			rdata_ff <= csc_ff;
		else if (bus_req.addr == TTS_BIS_ADDR)
			rdata_ff <= {2'b00, clock_loss_status_ff, 5'b00000};
		else if (bus_req.addr == TTS_STAT_ADDR)
			rdata_ff <= {3'b000, viol_pending, lost, tx_src_ff, sub_active};
		else
			rdata_ff <= 8'h00;
	end

	// ==========================================================
	// Checks.
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	sequence s_arm;
		wr_csc && bus_req.wdata[TTS_VIOL_BIT] && !csc_ff[TTS_VIOL_BIT];
	endsequence

	sequence s_fire;
		viol_pending && tx_bit_tick;
	endsequence

	a_viol_arm: assert property (s_arm |=> viol_pending)
		else $error("violation request not armed");
	a_viol_once: assert property (s_fire ##0 !arm_viol |=> violation_inject_ff ##1 !violation_inject_ff)
		else $error("violation pulse wrong");
	a_viol_cause: assert property (violation_inject_ff |-> $past(viol_pending) && $past(tx_bit_tick))
		else $error("violation without request");
	a_std_follow: assert property (wr_csc |=> ##1 line_standard_ff == $past(bus_req.wdata[TTS_STD_BIT], 2))
		else $error("line standard not applied");
	a_align_restart: assert property (align_active && ref_8k_tick |=> frame_start_ff && frame_cnt_ff == 9'h000)
		else $error("frame not aligned to reference");
	a_align_gated: assert property (tx_src_ff != TTS_SRC_PLL && !tx_bit_tick |=> !frame_start_ff)
		else $error("alignment acted off the PLL source");
	a_sub_enter: assert property (prot_en && sel_src == TTS_SRC_LINE && lost |=> tx_src_ff == TTS_SRC_PLL)
		else $error("no switch to PLL on loss");
	a_sub_leave: assert property (sel_src == TTS_SRC_LINE && !lost |=> tx_src_ff == TTS_SRC_LINE)
		else $error("line clock not restored");
	a_stat_gated: assert property ($rose(clock_loss_status_ff) |-> $past(prot_en) && $past(lost))
		else $error("status set while protection off");
	a_reset_vals: assert property (disable iff (1'b0) rst |=> csc_ff == TTS_CSC_RESET && !frame_start_ff)
		else $error("reset values wrong");
	a_src_decode: assert property (csc_ff[1:0] == 2'b01 |=> tx_src_ff == TTS_SRC_EXT)
		else $error("external source not selected");
	a_rsvd_zero: assert property (csc_ff[3:2] == 2'b00)
		else $error("reserved bits not zero");

	// ==========================================================
	// Further checks, one group for each concern. Each one names the rule that it guards.
	// Loss on the line source is the only case in which the PLL stands in for the line clock.
	sequence s_loss_line;
		prot_en && sel_src == TTS_SRC_LINE && lost;
	endsequence

	// A wrap is a bit slot at or above the last count with no reference restart in the same cycle.
	sequence s_wrap;
		tx_bit_tick && frame_cnt_ff >= frame_last && !(align_active && ref_8k_tick);
	endsequence

	// Violation pulses need a pending request; a repeated one does not arm again.
	// A request may wait up to one bit slot, so it must survive until a slot comes.
	a_viol_quiet: assert property (!viol_pending |=> !violation_inject_ff)
		else $error("violation pulse without pending request");
	a_viol_norearm: assert property (wr_csc && csc_ff[TTS_VIOL_BIT] && !viol_pending |=> !viol_pending)
		else $error("violation armed again without a rising edge");
	a_viol_hold: assert property (viol_pending && !tx_bit_tick |=> viol_pending)
		else $error("violation request lost before its slot");
	a_pend_clear: assert property (s_fire ##0 !arm_viol |=> !viol_pending)
		else $error("violation request not consumed");

	// Line standard and frame length. A change of standard mid-frame wraps at the next slot
	// when the counter then stands at or above the new last count.
	a_std_e1: assert property (!csc_ff[TTS_STD_BIT] |=> !line_standard_ff)
		else $error("E1 not selected");
	a_std_t1: assert property (csc_ff[TTS_STD_BIT] |=> line_standard_ff)
		else $error("T1 not selected");
	a_frame_wrap: assert property (s_wrap |=> frame_start_ff && frame_cnt_ff == 9'h000)
		else $error("frame did not wrap at its last slot");
	a_frame_len: assert property (tx_bit_tick && frame_cnt_ff < frame_last && !ref_8k_tick
		|=> !frame_start_ff)
		else $error("frame started before its last slot");
	a_ref_idle: assert property (!ref_8k_tick && !tx_bit_tick |=> !frame_start_ff)
		else $error("frame started with neither slot nor reference");

	// Reference alignment needs the enable bit and the PLL as the effective source.
	a_align_off: assert property (!csc_ff[TTS_ALIGN_BIT] && !tx_bit_tick |=> !frame_start_ff)
		else $error("frame aligned with alignment disabled");
	a_align_pll: assert property (csc_ff[TTS_ALIGN_BIT] && tx_src_ff == TTS_SRC_PLL && ref_8k_tick
		|=> frame_start_ff)
		else $error("reference tick ignored on the PLL source");

	// Source selection and substitution. The external clock is never replaced, since its loss
	// is not visible to the line interface.
	a_sub_status: assert property (s_loss_line
		|=> tx_src_ff == TTS_SRC_PLL && clock_loss_status_ff)
		else $error("loss on the line source not handled");
	a_regain_line: assert property (prot_en && sel_src == TTS_SRC_LINE && !lost
		|=> tx_src_ff == TTS_SRC_LINE)
		else $error("line clock not taken back after recovery");
	a_ext_kept: assert property (sel_src == TTS_SRC_EXT |=> tx_src_ff == TTS_SRC_EXT)
		else $error("external source replaced");
	a_noprot_line: assert property (!prot_en && sel_src == TTS_SRC_LINE |=> tx_src_ff == TTS_SRC_LINE)
		else $error("substitution with protection off");
	a_pll_select: assert property (csc_ff[1:0] == 2'b10 |=> tx_src_ff == TTS_SRC_PLL)
		else $error("PLL source not selected");
	a_code3_line: assert property (csc_ff[1:0] == 2'b11 && !lost |=> tx_src_ff == TTS_SRC_LINE)
		else $error("code three did not select the line clock");

	// Clock-loss status: sticky until read, and a loss in the read cycle keeps it set.
	// With protection off a loss leaves it alone, so software sees only protected losses.
	a_stat_set: assert property (prot_en && lost |=> clock_loss_status_ff)
		else $error("status not set on a protected loss");
	a_stat_sticky: assert property (clock_loss_status_ff && !rd_bis |=> clock_loss_status_ff)
		else $error("status dropped without a read");
	a_stat_clear: assert property (rd_bis && !(prot_en && lost) |=> !clock_loss_status_ff)
		else $error("status not cleared by its read");
	a_stat_off: assert property (!prot_en && !clock_loss_status_ff |=> !clock_loss_status_ff)
		else $error("status set with protection off");
	a_stat_read: assert property (rd_bis |=> rdata_ff[TTS_CLKLOSS_BIT] == $past(clock_loss_status_ff))
		else $error("status read back wrong");

	// Register read-back and reset values.
	a_rsvd_read: assert property (bus_req.rd && bus_req.addr == TTS_CSC_ADDR
		|=> rdata_ff[3:2] == 2'b00)
		else $error("reserved bits read back set");
	a_reset_outs: assert property (disable iff (1'b0) rst
		|=> tx_src_ff == TTS_SRC_LINE && !line_standard_ff && !violation_inject_ff && !clock_loss_status_ff)
		else $error("outputs not cleared by reset");

endmodule : tts_ctrl

/* File: design/tts_loss_mon.sv */
// Recovered line clock loss monitor.
`timescale 1ns/10ps
module tts_loss_mon
	import tts_pkg::*;
#(
	parameter int LIMIT = TTS_LOSS_CYC
)
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic rec_tick,
	input wire logic recovery_ok,
	output logic lost_ff
);

	// Parameter check: the gap counter is twelve bits wide and a loss needs two silent cycles.
	if (LIMIT < 2 || LIMIT > 4095)
	begin : g_bad_limit
		$error("tts_loss_mon: LIMIT out of range");
	end

	logic [11:0] gap_ff;

	// ==========================================================
	// Count cycles since the last recovered clock tick; saturate at the limit.
	always_ff @(posedge mclk)
	begin
		if (rst)
			gap_ff <= 12'h000;
		else if (rec_tick)
			gap_ff <= 12'h000;
		else if (gap_ff != LIMIT[11:0])
			gap_ff <= gap_ff + 12'h001;
	end

	// Loss is either the interface's own flag or a silent clock; both must clear to recover.
	always_ff @(posedge mclk)
	begin
		if (rst)
			lost_ff <= 1'b0;
		else
			lost_ff <= !recovery_ok || (gap_ff == LIMIT[11:0] && !rec_tick);
	end

endmodule : tts_loss_mon

/* File: design/tts_pkg.sv */
// Shared constants, types and register layout for the transmit timing select control.
package tts_pkg;

	// ==========================================================
	// Register map.
	localparam logic [11:0] TTS_CSC_ADDR = 12'h100;
	localparam logic [11:0] TTS_BIS_ADDR = 12'hb00;
	localparam logic [11:0] TTS_STAT_ADDR = 12'h104;

	// ==========================================================
	// Field positions and reset values.
	localparam int TTS_VIOL_BIT = 7;
	localparam int TTS_STD_BIT = 6;
	localparam int TTS_ALIGN_BIT = 5;
	localparam int TTS_PROT_BIT = 4;
	localparam int TTS_CLKLOSS_BIT = 5;
	localparam logic [7:0] TTS_CSC_RESET = 8'h11;
	localparam logic [7:0] TTS_CSC_WMASK = 8'hf3;

	// ==========================================================
	// Timing.
	localparam int TTS_CLK_PERIOD_NS = 100;
	localparam int TTS_LOSS_TIME_NS = 2000;
	localparam int TTS_LOSS_CYC = (TTS_LOSS_TIME_NS + TTS_CLK_PERIOD_NS - 1) / TTS_CLK_PERIOD_NS;
	localparam int TTS_T1_FRAME_BITS = 193;
	localparam int TTS_E1_FRAME_BITS = 256;

	// ==========================================================
	// Types.
	typedef enum logic [1:0]
	{
		TTS_SRC_LINE = 2'b00,
		TTS_SRC_EXT = 2'b01,
		TTS_SRC_PLL = 2'b10
	} tts_src_t;

	typedef struct packed
	{
		logic rd;
		logic wr;
		logic [11:0] addr;
		logic [7:0] wdata;
	} tts_bus_req_t;

endpackage : tts_pkg

/* File: design/tts_viol_gen.sv */
// Single line code violation request generator.
`timescale 1ns/10ps
module tts_viol_gen
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic arm,
	input wire logic bit_tick,
	output logic pending_ff,
	output logic viol_ff
);

	// ==========================================================
	// A request waits for the next transmit bit slot, so the violation lands on a real pulse.
	// A second arm while one is pending merges into it; software cannot rise faster anyway.
	always_ff @(posedge mclk)
	begin
		if (rst)
			pending_ff <= 1'b0;
		else if (arm)
			pending_ff <= 1'b1;
		else if (bit_tick)
			pending_ff <= 1'b0;
	end

	// One cycle pulse per request.
	always_ff @(posedge mclk)
	begin
		if (rst)
			viol_ff <= 1'b0;
		else
			viol_ff <= pending_ff && bit_tick;
	end

endmodule : tts_viol_gen

/* File: tb/tb_tts_ctrl.sv */
// Self-checking bench for the transmit timing select control.
`timescale 1ns/10ps
module tb_tts_ctrl
	import tts_pkg::*;
;
	localparam int T1B = 5;
	localparam int E1B = 7;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	tts_bus_req_t bus_req = '0;
	logic bit_en = 1'b0;
	logic rec_on = 1'b1;
	logic ref_req = 1'b0;
	logic rec_clk_tick, recovery_ok, tx_bit_tick, ref_8k_tick;
	logic [7:0] rdata_ff;
	tts_src_t tx_src_ff;
	logic line_standard_ff, violation_inject_ff, frame_start_ff, clock_loss_status_ff;
	int err_total = 0;
	int total_checks = 0;
	int cyc = 0;
	int vcnt = 0;
	int fcnt = 0;
	int ticks = 0;
	int flen = 0;
	int csc_m;
	logic [7:0] d;
	tts_line_model line (.mclk, .rst, .bit_en, .rec_on, .ref_req, .rec_clk_tick, .recovery_ok,
		.tx_bit_tick, .ref_8k_tick);
	tts_ctrl #(.T1_BITS(T1B), .E1_BITS(E1B), .LOSS_LIMIT(4)) dut (.mclk, .rst, .bus_req, .rdata_ff,
		.rec_clk_tick, .recovery_ok, .tx_bit_tick, .ref_8k_tick, .tx_src_ff, .line_standard_ff,
		.violation_inject_ff, .frame_start_ff, .clock_loss_status_ff);
	// ==========================================
	// Clock.
	initial
	begin
		forever #50 mclk = ~mclk;
	end
	// Pulse counters and frame length, plus the hang limit.
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (violation_inject_ff === 1'b1)
			vcnt <= vcnt + 1;
		if (frame_start_ff === 1'b1)
		begin
			fcnt <= fcnt + 1;
			flen <= ticks;
			ticks <= 0;
		end
		else if (tx_bit_tick === 1'b1)
			ticks <= ticks + 1;
		if (cyc == 5000)
		begin
			err_total++;
			report_and_stop();
		end
	end
	// ==========================================
	// Tasks.
	task automatic wait_c(input int n);
		repeat (n) @(posedge mclk);
	endtask : wait_c
	// One bus cycle; the model copy of the register follows every write.
	task automatic bus(input logic r, input logic [11:0] a, input logic [7:0] w);
		@(posedge mclk);
		bus_req <= {r, ~r, a, w};
		@(posedge mclk);
		bus_req <= '0;
		#1 d = rdata_ff;
		if (!r && a == TTS_CSC_ADDR)
			csc_m = w & 8'hf3;
	endtask : bus
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic report_and_stop();
		$display("checks=%0d errors=%0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : report_and_stop
	// ==========================================
	// Main sequence.
	initial
	begin
		int n;
		logic [7:0] v;
		logic [7:0] av [3];
		av = '{8'h22, 8'h21, 8'h02};
		void'($urandom(32'hb29c));
		wait_c(8);
		rst <= 1'b0;
		bus(1'b1, TTS_CSC_ADDR, 8'h00);
		chk(d, 8'h11);
		chk(tx_src_ff, TTS_SRC_EXT);
		bus(1'b1, 12'h123, 8'h00);
		chk(d, 8'h00);
		$display("test 1 done");
		// Random values, reserved bits kept at zero.
		repeat (4)
		begin
			v = $urandom;
			bus(1'b0, TTS_CSC_ADDR, v & 8'hf3);
			bus(1'b1, TTS_CSC_ADDR, 8'h00);
			chk(d, csc_m[7:0]);
		end
		$display("test 2 done");
		for (int k = 0; k < 4; k++)
		begin
			bus(1'b0, TTS_CSC_ADDR, 8'(k));
			wait_c(3);
			chk(tx_src_ff, k == 2 ? TTS_SRC_PLL : (k == 1 ? TTS_SRC_EXT : TTS_SRC_LINE));
		end
		$display("test 3 done");
		bit_en <= 1'b1;
		for (int k = 0; k < 2; k++)
		begin
			bus(1'b0, TTS_CSC_ADDR, k ? 8'h40 : 8'h00);
			wait_c(80);
			chk(line_standard_ff, 8'(k));
			chk(8'(flen), k ? 8'(T1B) : 8'(E1B));
		end
		$display("test 4 done");
		n = vcnt;
		bus(1'b0, TTS_CSC_ADDR, 8'h80);
		bus(1'b0, TTS_CSC_ADDR, 8'h80);
		wait_c(12);
		chk(8'(vcnt - n), 8'h01);
		bus(1'b0, TTS_CSC_ADDR, 8'h00);
		bus(1'b0, TTS_CSC_ADDR, 8'h80);
		wait_c(12);
		chk(8'(vcnt - n), 8'h02);
		$display("test 5 done");
		bus(1'b0, TTS_CSC_ADDR, 8'h10);
		rec_on <= 1'b0;
		wait_c(8);
		chk(tx_src_ff, TTS_SRC_PLL);
		chk(clock_loss_status_ff, 8'h01);
		bus(1'b1, TTS_STAT_ADDR, 8'h00);
		chk(d, 8'h0d);
		bus(1'b1, TTS_BIS_ADDR, 8'h00);
		chk(d, 8'h20);
		rec_on <= 1'b1;
		wait_c(8);
		chk(tx_src_ff, TTS_SRC_LINE);
		bus(1'b1, TTS_BIS_ADDR, 8'h00);
		chk(d, 8'h20);
		bus(1'b1, TTS_BIS_ADDR, 8'h00);
		chk(d, 8'h00);
		bus(1'b0, TTS_CSC_ADDR, 8'h00);
		rec_on <= 1'b0;
		wait_c(8);
		chk(tx_src_ff, TTS_SRC_LINE);
		bus(1'b1, TTS_BIS_ADDR, 8'h00);
		chk(d, 8'h00);
		rec_on <= 1'b1;
		$display("test 6 done");
		// Bit ticks stop so that only the reference can start a frame.
		bit_en <= 1'b0;
		for (int k = 0; k < 3; k++)
		begin
			bus(1'b0, TTS_CSC_ADDR, av[k]);
			wait_c(4);
			n = fcnt;
			ref_req <= 1'b1;
			@(posedge mclk);
			ref_req <= 1'b0;
			wait_c(4);
			chk(8'(fcnt - n), k == 0 ? 8'h01 : 8'h00);
		end
		$display("test 7 done");
		// A reset in mid-run must restore the defaults over whatever software wrote.
		bus(1'b0, TTS_CSC_ADDR, 8'h70);
		wait_c(2);
		chk(line_standard_ff, 8'h01);
		rst <= 1'b1;
		wait_c(2);
		rst <= 1'b0;
		bus(1'b1, TTS_CSC_ADDR, 8'h00);
		chk(d, TTS_CSC_RESET);
		chk(line_standard_ff, 8'h00);
		chk(tx_src_ff, TTS_SRC_EXT);
		$display("test 8 done");
		report_and_stop();
	end
endmodule : tb_tts_ctrl

/* File: tb/tts_line_model.sv */
// Behavioural model of the line interface that feeds the timing control.
`timescale 1ns/10ps
module tts_line_model
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic bit_en,
	input wire logic rec_on,
	input wire logic ref_req,
	output logic rec_clk_tick,
	output logic recovery_ok,
	output logic tx_bit_tick,
	output logic ref_8k_tick
);
	logic [1:0] div_ff;
	// ==========================================
	// Tick generation.
	// Recovered ticks stop while recovery is gone, as a dead line would give none.
	always_ff @(posedge mclk)
	begin
		div_ff <= rst ? 2'h0 : div_ff + 2'h1;
		rec_clk_tick <= rec_on & div_ff[0];
		recovery_ok <= rec_on;
		tx_bit_tick <= bit_en & (div_ff == 2'h3);
		ref_8k_tick <= ref_req;
	end
endmodule : tts_line_model
